// >>> pmc_defines.vh
/*
 Constants for the punch and monitor controller: time-code field layout,
 pre/post-roll limits and reset values, monitor source codes, attenuation.
 Assumes inclusion by pmc_top.v and by the self-checking bench.
*/
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH
// ==========================================
// time code layout {hh,mm,ss,ff,sf}
`define PMC_TC_W          32
`define PMC_SF_LSB        0
`define PMC_FF_LSB        8
`define PMC_SS_LSB        16
`define PMC_MM_LSB        22
`define PMC_HH_LSB        28
// ==========================================
// roll limits in seconds
`define PMC_PRE_MIN_S     12'd5
`define PMC_POST_MIN_S    12'd3
`define PMC_ROLL_MAX_S    12'd3599
`define PMC_PRE_RST_S     12'd5
`define PMC_POST_RST_S    12'd3
// ==========================================
// monitor source codes
`define PMC_MON_TAPE      2'h0
`define PMC_MON_INPUT     2'h1
`define PMC_MON_MUTE      2'h2
`define PMC_SHUTTLE_ATT_DB 5'd12
// ==========================================
// register map (word byte addresses)
`define PMC_A_CTRL        8'h00
`define PMC_A_ROLL        8'h04
`define PMC_A_PIN         8'h08
`define PMC_A_POUT        8'h0C
`define PMC_A_MEMA        8'h10
`define PMC_A_MEMB        8'h14
`define PMC_A_STAT        8'h18
`define PMC_A_ARM         8'h1C
`endif

// >>> pmc_top.v
/*
 Punch-in sequencing, locate-key routing, location memories and per-track
 monitor source selection for an eight-track recorder, with a Wishbone slave.
 Assumes key inputs are single-cycle pulses from synchronous panel logic and
 tape position is a synchronous BCD-like time code from the transport counter.
*/
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.vh"
// What this block does
// - during rehearsal or punch, locate_first relocates to punch-in minus pre-roll, no stop.
// - after that relocation, play restarts the same rehearsal or punch sequence.
// - during rehearsal or punch, locate_second relocates to punch-out minus pre-roll.
// - punch locate behaviour only while rehearsal or auto-punch lamp lit/flashing.
// - auto_punch key at pre-roll enters auto-punch with flashing lamp; play starts take.
// - at punch-in, record and armed lamps steady; with auto monitor on, armed tracks go source, lamps on.
// - recording happens on armed tracks only between punch-in and punch-out.
// - at punch-out armed tracks return to tape; at post-roll rewind to pre-roll.
// - after a completed take the auto-punch lamp turns steady: replay mode.
// - in replay, play plays with armed lamps flashing; post-roll rewinds to pre-roll.
// - auto_punch key in replay returns to flashing auto-punch mode for a new take.
// - clear leaves punch or rehearsal modes; punch times stay stored.
// - a track in playback monitors off-tape unless another setting overrides.
// - force source monitor lights its lamp and puts input on every track.
// - force source monitor beats both shuttle settings.
// - auto monitor puts armed tracks on source while recording or rehearsing.
// - shuttle_source_select ignored whenever auto monitor is off.
// - shuttle with auto monitor: armed tracks input if select on, else tape.
// - shuttle monitoring is attenuated by 12 dB.
// - shuttle_source_select is a two-value flag set by up and down keys in menu 2.
// - shuttle_silence mutes off-tape output during shuttle.
// - two location memories, each recalled by its own locate key.
// - shift plus memory key stores current position in any transport state.
// - while rehearsal lamp lit or flashing nothing is actually recorded.
// - pre-roll 5 s and post-roll 3 s minimum, up to 59 min 59 s, whole seconds.
module pmc_top (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        rehearsal_key_i,
	input  wire        auto_punch_key_i,
	input  wire        play_key_i,
	input  wire        clear_key_i,
	input  wire        locate_first_i,
	input  wire        locate_second_i,
	input  wire        shift_i,
	input  wire        menu_up_i,
	input  wire        menu_down_i,
	input  wire        menu_audio2_i,
	input  wire        shuttle_i,
	input  wire        tape_running_i,
	input  wire        record_xport_i,
	input  wire        locate_done_i,
	input  wire [31:0] tape_pos_i,
	input  wire [7:0]  track_arm_i,
	output reg         locate_req_o,
	output reg  [31:0] locate_pos_o,
	output reg         play_cmd_o,
	output reg         rehearsal_lamp_o,
	output reg         rehearsal_flash_o,
	output reg         auto_punch_lamp_o,
	output reg         auto_punch_flash_o,
	output reg         record_lamp_o,
	output reg  [7:0]  track_arm_steady_o,
	output reg  [7:0]  record_enable_o,
	output reg  [7:0]  source_monitor_lamp_o,
	output reg  [15:0] monitor_sel_o,
	output reg  [4:0]  monitor_att_db_o,
	output reg         force_src_lamp_o,
	output reg         auto_source_monitor_lamp_o,
	output reg         stored_msg_o
);
	// ==========================================
	// punch modes
	localparam MD_OFF    = 2'd0;
	localparam MD_REHEARSAL_KEY   = 2'd1;
	localparam MD_PUNCH  = 2'd2;
	localparam MD_REPLAY = 2'd3;
	// take phases
	localparam PH_IDLE = 2'd0;
	localparam PH_PRE  = 2'd1;
	localparam PH_IN   = 2'd2;
	localparam PH_POST = 2'd3;

	reg [1:0]  mode_r;
	reg [1:0]  phase_r;
	reg        rehearsal_key_steady_r;
	reg        force_src_r;
	reg        auto_source_monitor_r;
	reg        shtl_sel_r;
	reg        shtl_mute_r;
	reg [11:0] pre_s_r;
	reg [11:0] post_s_r;
	reg [31:0] pin_r;
	reg [31:0] pout_r;
	reg [31:0] mem_a_r;
	reg [31:0] mem_b_r;

	// ==========================================
	// time code arithmetic
	function [31:0] tc_sub_s;
		input [31:0] tc;
		input [11:0] secs;
		reg   [17:0] tot;
		reg   [17:0] q_h, q_m, q_s;
		reg   [17:0] res;
		begin
			tot = {4'h0, tc[`PMC_HH_LSB +: 4]} * 18'd3600 + {12'h000, tc[`PMC_MM_LSB +: 6]} * 18'd60
				+ {12'h000, tc[`PMC_SS_LSB +: 6]};
			res = (tot > {6'h00, secs}) ? tot - {6'h00, secs} : 18'h00000;
			q_h = res / 18'd3600;
			q_m = (res % 18'd3600) / 18'd60;
			q_s = res % 18'd60;
			tc_sub_s = tc;
			tc_sub_s[`PMC_HH_LSB +: 4] = q_h[3:0];
			tc_sub_s[`PMC_MM_LSB +: 6] = q_m[5:0];
			tc_sub_s[`PMC_SS_LSB +: 6] = q_s[5:0];
		end
	endfunction

	function [31:0] tc_add_s;
		input [31:0] tc;
		input [11:0] secs;
		reg   [17:0] res;
		reg   [17:0] q_h, q_m, q_s;
		begin
			res = {4'h0, tc[`PMC_HH_LSB +: 4]} * 18'd3600 + {12'h000, tc[`PMC_MM_LSB +: 6]} * 18'd60
				+ {12'h000, tc[`PMC_SS_LSB +: 6]} + {6'h00, secs};
			q_h = res / 18'd3600;
			q_m = (res % 18'd3600) / 18'd60;
			q_s = res % 18'd60;
			tc_add_s = tc;
			tc_add_s[`PMC_HH_LSB +: 4] = q_h[3:0];
			tc_add_s[`PMC_MM_LSB +: 6] = q_m[5:0];
			tc_add_s[`PMC_SS_LSB +: 6] = q_s[5:0];
		end
	endfunction

	function [11:0] clamp_roll;
		input [31:0] v;
		input [11:0] lo;
		begin
			if (v[11:0] < lo || v[31:12] != 20'h00000) begin
				clamp_roll = (v[31:12] != 20'h00000) ? `PMC_ROLL_MAX_S : lo;
			end else if (v[11:0] > `PMC_ROLL_MAX_S) begin
				clamp_roll = `PMC_ROLL_MAX_S;
			end else begin
				clamp_roll = v[11:0];
			end
		end
	endfunction

	wire [31:0] preroll_pt  = tc_sub_s(pin_r, pre_s_r);
	wire [31:0] postroll_pt = tc_add_s(pout_r, post_s_r);
	wire        punch_lamps = (mode_r != MD_OFF);
	wire        at_pin      = tape_running_i && (tape_pos_i >= pin_r) && (tape_pos_i < pout_r);
	wire        past_pout   = tape_pos_i >= pout_r;
	wire        past_post   = tape_pos_i >= postroll_pt;
	wire        wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        wb_wr       = wb_req && wb_we_i && (wb_sel_i == 4'hF);

	// ==========================================
	// bus slave, one wait state, unmapped reads zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_adr_i == `PMC_A_CTRL) begin
				wb_dat_o <= {28'h0000000, shtl_mute_r, shtl_sel_r, auto_source_monitor_r, force_src_r};
			end else if (wb_adr_i == `PMC_A_ROLL) begin
				wb_dat_o <= {4'h0, post_s_r, 4'h0, pre_s_r};
			end else if (wb_adr_i == `PMC_A_PIN) begin
				wb_dat_o <= pin_r;
			end else if (wb_adr_i == `PMC_A_POUT) begin
				wb_dat_o <= pout_r;
			end else if (wb_adr_i == `PMC_A_MEMA) begin
				wb_dat_o <= mem_a_r;
			end else if (wb_adr_i == `PMC_A_MEMB) begin
				wb_dat_o <= mem_b_r;
			end else if (wb_adr_i == `PMC_A_STAT) begin
				wb_dat_o <= {26'h0000000, rehearsal_key_steady_r, 1'b0, phase_r, mode_r};
			end else if (wb_adr_i == `PMC_A_ARM) begin
				wb_dat_o <= {24'h000000, track_arm_i};
			end else begin
				wb_dat_o <= 32'h00000000;
			end
		end
	end

	// ==========================================
	// settings and memories
	always @(posedge clk_i) begin
		if (rst_i) begin
			force_src_r <= 1'b0;
			auto_source_monitor_r  <= 1'b0;
			shtl_sel_r  <= 1'b0;
			shtl_mute_r <= 1'b0;
			pre_s_r     <= `PMC_PRE_RST_S;
			post_s_r    <= `PMC_POST_RST_S;
			pin_r       <= 32'h00000000;
			pout_r      <= 32'h00000000;
			mem_a_r     <= 32'h00000000;
			mem_b_r     <= 32'h00000000;
			stored_msg_o <= 1'b0;
		end else begin
			stored_msg_o <= 1'b0;
			if (wb_wr && wb_adr_i == `PMC_A_CTRL) begin
				force_src_r <= wb_dat_i[0];
				auto_source_monitor_r  <= wb_dat_i[1];
				shtl_mute_r <= wb_dat_i[3];
			end
			if (wb_wr && wb_adr_i == `PMC_A_ROLL) begin
				pre_s_r  <= clamp_roll({20'h00000, wb_dat_i[11:0]}, `PMC_PRE_MIN_S);
				post_s_r <= clamp_roll({20'h00000, wb_dat_i[27:16]}, `PMC_POST_MIN_S);
			end
			if (wb_wr && wb_adr_i == `PMC_A_PIN) begin
				pin_r <= wb_dat_i;
			end
			if (wb_wr && wb_adr_i == `PMC_A_POUT) begin
				pout_r <= wb_dat_i;
			end
			if (menu_audio2_i && menu_up_i) begin
				shtl_sel_r <= 1'b1;
			end else if (menu_audio2_i && menu_down_i) begin
				shtl_sel_r <= 1'b0;
			end
			if (shift_i && locate_first_i) begin
				mem_a_r      <= tape_pos_i;
				stored_msg_o <= 1'b1;
			end else if (wb_wr && wb_adr_i == `PMC_A_MEMA) begin
				mem_a_r <= wb_dat_i;
			end
			if (shift_i && locate_second_i) begin
				mem_b_r      <= tape_pos_i;
				stored_msg_o <= 1'b1;
			end else if (wb_wr && wb_adr_i == `PMC_A_MEMB) begin
				mem_b_r <= wb_dat_i;
			end
		end
	end

	// ==========================================
	// punch sequencer
	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_r        <= MD_OFF;
			phase_r       <= PH_IDLE;
			rehearsal_key_steady_r <= 1'b0;
			locate_req_o  <= 1'b0;
			locate_pos_o  <= 32'h00000000;
			play_cmd_o    <= 1'b0;
		end else begin
			locate_req_o <= 1'b0;
			play_cmd_o   <= 1'b0;
			if (clear_key_i) begin
				mode_r        <= MD_OFF;
				phase_r       <= PH_IDLE;
				rehearsal_key_steady_r <= 1'b0;
			end else if (!shift_i && locate_first_i) begin
				locate_req_o <= 1'b1;
				if (punch_lamps) begin
					locate_pos_o <= preroll_pt;
					phase_r      <= PH_IDLE;
				end else begin
					locate_pos_o <= mem_a_r;
				end
			end else if (!shift_i && locate_second_i) begin
				locate_req_o <= 1'b1;
				if (punch_lamps) begin
					locate_pos_o <= tc_sub_s(pout_r, pre_s_r);
					phase_r      <= PH_IDLE;
				end else begin
					locate_pos_o <= mem_b_r;
				end
			end else if (rehearsal_key_i && !shift_i) begin
				mode_r        <= MD_REHEARSAL_KEY;
				rehearsal_key_steady_r <= (mode_r == MD_REHEARSAL_KEY) ? ~rehearsal_key_steady_r : 1'b0;
			end else if (auto_punch_key_i && (tape_pos_i <= preroll_pt || mode_r == MD_REPLAY)) begin
				mode_r  <= MD_PUNCH;
				phase_r <= PH_IDLE;
			end else if (play_key_i && punch_lamps) begin
				play_cmd_o <= 1'b1;
				phase_r    <= PH_PRE;
			end else begin
				case (phase_r)
					PH_PRE: begin
						if (at_pin) begin
							phase_r <= PH_IN;
						end
					end
					PH_IN: begin
						if (past_pout) begin
							phase_r <= PH_POST;
						end
					end
					PH_POST: begin
						if (past_post) begin
							locate_req_o <= 1'b1;
							locate_pos_o <= preroll_pt;
							phase_r      <= PH_IDLE;
							if (mode_r == MD_PUNCH) begin
								mode_r <= MD_REPLAY;
							end else if (mode_r == MD_REHEARSAL_KEY) begin
								rehearsal_key_steady_r <= 1'b1;
							end
						end
					end
					default: begin
						phase_r <= PH_IDLE;
					end
				endcase
			end
		end
	end

	// ==========================================
	// lamps, record gating and monitor selection per track
	wire punch_win = (phase_r == PH_IN) && (mode_r == MD_PUNCH || mode_r == MD_REHEARSAL_KEY);
	always @(posedge clk_i) begin
		if (rst_i) begin
			rehearsal_lamp_o   <= 1'b0;
			rehearsal_flash_o  <= 1'b0;
			auto_punch_lamp_o  <= 1'b0;
			auto_punch_flash_o <= 1'b0;
			record_lamp_o      <= 1'b0;
			force_src_lamp_o   <= 1'b0;
			auto_source_monitor_lamp_o    <= 1'b0;
			monitor_att_db_o   <= 5'd0;
		end else begin
			rehearsal_lamp_o   <= (mode_r == MD_REHEARSAL_KEY);
			rehearsal_flash_o  <= (mode_r == MD_REHEARSAL_KEY) && !rehearsal_key_steady_r;
			auto_punch_lamp_o  <= (mode_r == MD_PUNCH) || (mode_r == MD_REPLAY);
			auto_punch_flash_o <= (mode_r == MD_PUNCH);
			record_lamp_o      <= punch_win && (mode_r == MD_PUNCH);
			force_src_lamp_o   <= force_src_r;
			auto_source_monitor_lamp_o    <= auto_source_monitor_r;
			monitor_att_db_o   <= shuttle_i ? `PMC_SHUTTLE_ATT_DB : 5'd0;
		end
	end

	genvar t;
	generate
		for (t = 0; t < 8; t = t + 1) begin : g_trk
			reg [1:0] sel_nxt;
			reg       src_nxt;
			always @* begin
				src_nxt = track_arm_i[t] && auto_source_monitor_r && (punch_win || (record_xport_i && mode_r == MD_OFF));
				if (force_src_r) begin
					sel_nxt = `PMC_MON_INPUT;
				end else if (shuttle_i && shtl_mute_r) begin
					sel_nxt = `PMC_MON_MUTE;
				end else if (shuttle_i && auto_source_monitor_r && track_arm_i[t] && shtl_sel_r) begin
					sel_nxt = `PMC_MON_INPUT;
				end else if (!shuttle_i && src_nxt) begin
					sel_nxt = `PMC_MON_INPUT;
				end else begin
					sel_nxt = `PMC_MON_TAPE;
				end
			end
			always @(posedge clk_i) begin
				if (rst_i) begin
					monitor_sel_o[2*t +: 2]  <= `PMC_MON_TAPE;
					source_monitor_lamp_o[t] <= 1'b0;
					track_arm_steady_o[t]    <= 1'b0;
					record_enable_o[t]       <= 1'b0;
				end else begin
					monitor_sel_o[2*t +: 2]  <= sel_nxt;
					source_monitor_lamp_o[t] <= (sel_nxt == `PMC_MON_INPUT) && !force_src_r && src_nxt;
					track_arm_steady_o[t]    <= track_arm_i[t] && punch_win;
					record_enable_o[t]       <= track_arm_i[t] && punch_win && (mode_r == MD_PUNCH);
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// >>> pmc_top_properties.sv
/* Port-level assertions for pmc_top.
   Assumes a bind onto pmc_top; one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module pmc_top_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        shuttle_i,
	input wire logic        clear_key_i,
	input wire logic        shift_i,
	input wire logic        locate_first_i,
	input wire logic        locate_second_i,
	input wire logic        locate_req_o,
	input wire logic        rehearsal_lamp_o,
	input wire logic        auto_punch_lamp_o,
	input wire logic        record_lamp_o,
	input wire logic [7:0]  record_enable_o,
	input wire logic [15:0] monitor_sel_o,
	input wire logic [4:0]  monitor_att_db_o,
	input wire logic        force_src_lamp_o,
	input wire logic        auto_source_monitor_lamp_o,
	input wire logic        stored_msg_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// properties
	rehearsal_key_no_write_a: assert property (|record_enable_o |-> !rehearsal_lamp_o)
		else $error("write enable while rehearsing");
	rec_lamp_a: assert property (|record_enable_o |-> record_lamp_o)
		else $error("write enable without record lamp");
	force_all_a: assert property (force_src_lamp_o && $past(force_src_lamp_o) |-> monitor_sel_o == 16'h5555)
		else $error("forced source not on every track");
	shuttle_att_a: assert property (!$past(rst_i) |-> monitor_att_db_o == ($past(shuttle_i) ? 5'h0C : 5'h00))
		else $error("shuttle attenuation wrong");
	clear_exit_a: assert property (clear_key_i |-> ##2 !rehearsal_lamp_o && !auto_punch_lamp_o)
		else $error("clear left a punch lamp on");
	capture_msg_a: assert property (shift_i && (locate_first_i || locate_second_i) && !clear_key_i
		|=> stored_msg_o ##1 !stored_msg_o)
		else $error("capture message missing");
	loc_first_a: assert property (locate_first_i && !shift_i && !clear_key_i |=> locate_req_o)
		else $error("first locate not issued");
	loc_second_a: assert property (locate_second_i && !locate_first_i && !shift_i && !clear_key_i |=> locate_req_o)
		else $error("second locate not issued");
	tape_default_a: assert property (!force_src_lamp_o && !auto_source_monitor_lamp_o && !shuttle_i && $past(!shuttle_i)
		&& $stable(force_src_lamp_o) && $stable(auto_source_monitor_lamp_o) |-> monitor_sel_o == 16'h0000)
		else $error("plain monitoring not off-tape");
endmodule
`default_nettype wire

// >>> pmc_xport_model.sv
/* Transport stand-in: jumps on locate, runs on play, one second per clock.
   Assumes pulse commands from pmc_top. */
`timescale 1ns/1ps
`default_nettype none
module pmc_xport_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        locate_req_i,
	input  wire logic [31:0] locate_pos_i,
	input  wire logic        play_cmd_i,
	output var  logic [31:0] tape_pos_o,
	output var  logic        running_o,
	output var  logic        done_o
);
	// ==========================================
	// motion
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rst_i) begin
			tape_pos_o <= 32'h0;
			running_o <= 1'b0;
		end else if (locate_req_i) begin
			tape_pos_o <= locate_pos_i;
			running_o <= 1'b0;
			done_o <= 1'b1;
		end else if (play_cmd_i) begin
			running_o <= 1'b1;
		end else if (running_o && tape_pos_o[21:16] == 6'h3B) begin
			tape_pos_o[21:16] <= 6'h00;
			tape_pos_o[27:22] <= tape_pos_o[27:22] + 6'h01;
		end else if (running_o) begin
			tape_pos_o[21:16] <= tape_pos_o[21:16] + 6'h01;
		end
	end
endmodule
`default_nettype wire

// >>> pmc_top_tb_top.sv
/* Self-checking bench for pmc_top with a transport stand-in.
   Assumes pmc_defines.vh offsets and a 250 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.vh"
module pmc_top_tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        shift_i = 1'b0;
	logic        shuttle_i = 1'b0;
	logic        menu_audio2_i = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [7:0]  k = 8'h00;
	logic [7:0]  track_arm_i = 8'h05;
	logic        rec_xport = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	int          failures = 0;
	int          checked = 0;
	wire logic [31:0] wb_dat_o, locate_pos_o, tape_pos;
	wire logic [15:0] monitor_sel_o;
	wire logic [7:0]  track_arm_steady_o, record_enable_o, source_monitor_lamp_o;
	wire logic [4:0]  monitor_att_db_o;
	wire logic        wb_ack_o, locate_req_o, play_cmd_o, running, done, stored_msg_o;
	wire logic        auto_punch_lamp_o, auto_punch_flash_o, record_lamp_o, force_src_lamp_o;
	wire logic        rehearsal_lamp_o, rehearsal_flash_o, auto_source_monitor_lamp_o;

	always #2 clk_i = ~clk_i;

	pmc_top pmc_top_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .rehearsal_key_i(k[0]),
		.auto_punch_key_i(k[1]), .play_key_i(k[2]), .clear_key_i(k[3]), .locate_first_i(k[4]),
		.locate_second_i(k[5]), .shift_i, .menu_up_i(k[6]), .menu_down_i(k[7]), .menu_audio2_i,
		.shuttle_i, .tape_running_i(running), .record_xport_i(rec_xport), .locate_done_i(done),
		.tape_pos_i(tape_pos), .track_arm_i, .locate_req_o, .locate_pos_o, .play_cmd_o,
		.rehearsal_lamp_o, .rehearsal_flash_o, .auto_punch_lamp_o, .auto_punch_flash_o,
		.record_lamp_o, .track_arm_steady_o, .record_enable_o, .source_monitor_lamp_o,
		.monitor_sel_o, .monitor_att_db_o, .force_src_lamp_o, .auto_source_monitor_lamp_o, .stored_msg_o);
	pmc_xport_model pmc_xport_model_inst (.clk_i, .rst_i, .locate_req_i(locate_req_o),
		.locate_pos_i(locate_pos_o), .play_cmd_i(play_cmd_o), .tape_pos_o(tape_pos),
		.running_o(running), .done_o(done));

	// ==========================================
	// helpers
	function automatic logic [31:0] tc(input logic [5:0] m, input logic [5:0] s);
		return {4'h0, m, s, 16'h0C03};
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task press(input int b);
		@(posedge clk_i);
		k[b] <= 1'b1;
		@(posedge clk_i);
		k <= 8'h00;
		#1;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("ack delay", 32'd2, n);
	endtask
	task mon(input logic [31:0] c, input logic [31:0] e);
		wb(1'b1, `PMC_A_CTRL, c);
		step(2);
		chk("monitor", e, {force_src_lamp_o, monitor_att_db_o, monitor_sel_o});
	endtask
	task report_and_stop;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========================================
	// scenarios
	task t_regs;
		wb(1'b1, `PMC_A_ROLL, 32'h0001_0002);
		wb(1'b0, `PMC_A_ROLL, 32'h0);
		chk("roll low", 32'h0003_0005, rdat);
		wb(1'b1, `PMC_A_ROLL, 32'h0FFF_0FFF);
		wb(1'b0, `PMC_A_ROLL, 32'h0);
		chk("roll high", 32'h0E0F_0E0F, rdat);
		wb(1'b1, `PMC_A_ROLL, 32'h0003_0005);
		wb(1'b1, `PMC_A_PIN, tc(6'h01, 6'h02));
		wb(1'b1, `PMC_A_POUT, tc(6'h01, 6'h14));
		wb(1'b1, `PMC_A_MEMA, tc(6'h00, 6'h39));
		wb(1'b1, `PMC_A_CTRL, 32'h2);
		wb(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, rdat);
		chk("auto lamp", 32'h1, auto_source_monitor_lamp_o);
	endtask
	task t_take;
		int n;
		press(4);
		chk("mem locate", tc(6'h00, 6'h39), locate_pos_o);
		press(1);
		step(2);
		chk("punch flash", 32'h3, {auto_punch_lamp_o, auto_punch_flash_o});
		press(2);
		chk("play", 32'h1, play_cmd_o);
		n = 0;
		while (record_enable_o === 8'h00 && n < 100) begin
			step(1);
			n++;
		end
		chk("rec tracks", 32'h05, record_enable_o);
		chk("arm steady", 32'h105, {record_lamp_o, track_arm_steady_o});
		chk("src mon", 32'h0000_1105, {monitor_sel_o, source_monitor_lamp_o});
		while (locate_req_o !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		chk("out tape", 32'h0, {monitor_sel_o, record_enable_o});
		chk("rewind", tc(6'h00, 6'h39), locate_pos_o);
		step(2);
		chk("replay lamp", 32'h2, {auto_punch_lamp_o, auto_punch_flash_o});
	endtask
	task t_replay;
		@(posedge clk_i);
		shift_i <= 1'b1;
		press(5);
		chk("stored", 32'h1, stored_msg_o);
		@(posedge clk_i);
		shift_i <= 1'b0;
		wb(1'b0, `PMC_A_MEMB, 32'h0);
		chk("mem b", tc(6'h00, 6'h39), rdat);
		press(2);
		step(10);
		chk("replay", 32'h0, {track_arm_steady_o, record_enable_o});
		press(4);
		chk("loc first", tc(6'h00, 6'h39), locate_pos_o);
		press(2);
		chk("restart", 32'h1, play_cmd_o);
		press(5);
		chk("loc second", tc(6'h01, 6'h0F), locate_pos_o);
		press(1);
		step(2);
		chk("punch again", 32'h3, {auto_punch_lamp_o, auto_punch_flash_o});
		press(3);
		step(2);
		chk("cleared", 32'h0, {auto_punch_lamp_o, auto_punch_flash_o});
		press(5);
		chk("normal loc", tc(6'h00, 6'h39), locate_pos_o);
		wb(1'b0, `PMC_A_PIN, 32'h0);
		chk("pin kept", tc(6'h01, 6'h02), rdat);
	endtask
	task t_rehearsal_key;
		int n;
		press(0);
		step(2);
		chk("rehearsal_key flash", 32'h3, {rehearsal_lamp_o, rehearsal_flash_o});
		press(0);
		press(5);
		chk("rehearsal_key loc second", tc(6'h01, 6'h0F), locate_pos_o);
		press(4);
		press(2);
		n = 0;
		while (track_arm_steady_o === 8'h00 && n < 100) begin
			step(1);
			n++;
		end
		chk("rehearsal_key no write", 32'h0, record_enable_o);
		chk("rehearsal_key src", 32'h0000_1105, {monitor_sel_o, source_monitor_lamp_o});
		while (locate_req_o !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		chk("rehearsal_key rewind", tc(6'h00, 6'h39), locate_pos_o);
		step(2);
		chk("rehearsal_key steady", 32'h2, {rehearsal_lamp_o, rehearsal_flash_o});
		press(3);
	endtask
	task t_mon;
		@(posedge clk_i);
		shuttle_i <= 1'b1;
		menu_audio2_i <= 1'b1;
		mon(32'h2, 32'h000C_0000);
		press(6);
		wb(1'b0, `PMC_A_CTRL, 32'h0);
		chk("flag up", 32'h6, rdat);
		mon(32'h2, 32'h000C_0011);
		mon(32'hA, 32'h000C_AAAA);
		mon(32'hB, 32'h002C_5555);
		mon(32'h0, 32'h000C_0000);
		press(7);
		wb(1'b0, `PMC_A_CTRL, 32'h0);
		chk("flag down", 32'h0, rdat);
		@(posedge clk_i);
		shuttle_i <= 1'b0;
		mon(32'h1, 32'h0020_5555);
		@(posedge clk_i);
		rec_xport <= 1'b1;
		mon(32'h2, 32'h0000_0011);
		mon(32'h0, 32'h0000_0000);
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_take();
		t_replay();
		t_rehearsal_key();
		t_mon();
		report_and_stop();
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		failures++;
		report_and_stop();
	end
endmodule
bind pmc_top pmc_top_chk pmc_top_chk_inst (.clk_i, .rst_i, .shuttle_i, .clear_key_i, .shift_i,
	.locate_first_i, .locate_second_i, .locate_req_o, .rehearsal_lamp_o, .auto_punch_lamp_o,
	.record_lamp_o, .record_enable_o, .monitor_sel_o, .monitor_att_db_o, .force_src_lamp_o,
	.auto_source_monitor_lamp_o, .stored_msg_o);
`default_nettype wire
